/* File: aod_ctrl.sv */
// Chosen here: the register addresses and the APB register port.
module aod_ctrl
  import aod_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  host_out_en,
  input  wire logic                  bp_power_ok,
  input  wire logic                  host_comm_ok,
  input  wire logic                  io_comm_ok,
  input  wire logic                  field_power_ok,
  input  wire logic                  over_temp,
  input  wire logic                  tb_present,
  input  wire logic                  hot_removal,
  input  wire logic                  analog_power_kept,
  input  wire logic [NCH-1:0]        chan_fault_raw,
  input  wire logic                  host_service_request,
  input  wire logic [7:0]            host_service_code,
  output logic [NCH*CW-1:0]          analog_output_table,
  output logic [NCH-1:0]             chan_fault,
  output logic                       fault_report,
  output logic                       irq
);
  import aod_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] chcfg [NCH];
  logic [31:0] dflt [NCH];
  logic [31:0] rate [NCH];
  logic [31:0] cmd [NCH];
  logic [31:0] outv [NCH];
  logic [7:0]  fdbk_len;
  logic [8:0]  diag_len;
  logic [5:0]  stat_len;
  logic [1:0]  s_hen, s_bp, s_hc, s_io, s_fp, s_ot, s_tb, s_hr, s_ap;
  logic [NCH-1:0] s_cf;
  logic        first_store;
  logic        cfg_event;
  logic        cfg_pend;
  logic        cfg_mode;
  logic        svc_hold;
  logic [15:0] tick_cnt;
  logic        tick;
  aod_mode_t   mode;
  logic        wr;
  logic        rd;
  logic [3:0]  idx;
  logic [7:0]  cmd_words;

  // two-stage sync on every field-side input; stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_hen <= '0; s_bp <= '0; s_hc <= '0; s_io <= '0; s_fp <= '0;
      s_ot <= '0; s_tb <= '0; s_hr <= '0; s_ap <= '0;
    end else begin
      s_hen <= {s_hen[0], host_out_en};
      s_bp  <= {s_bp[0], bp_power_ok};
      s_hc  <= {s_hc[0], host_comm_ok};
      s_io  <= {s_io[0], io_comm_ok};
      s_fp  <= {s_fp[0], field_power_ok};
      s_ot  <= {s_ot[0], over_temp};
      s_tb  <= {s_tb[0], tb_present};
      s_hr  <= {s_hr[0], hot_removal};
      s_ap  <= {s_ap[0], analog_power_kept};
    end
  end
  logic [NCH-1:0] s_cf0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_cf0 <= '0;
      s_cf <= '0;
    end else begin
      s_cf0 <= chan_fault_raw;
      s_cf <= s_cf0;
    end
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign idx = paddr[5:2];
  assign cmd_words = ctrl[C_VAR8] ? CMD_WORDS_8 : CMD_WORDS_4;

  // update tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 16'(UPD_CYC - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      fdbk_len <= '0;
      diag_len <= '0;
      stat_len <= '0;
      cfg_event <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        chcfg[i] <= CHCFG_RST;
        dflt[i] <= '0;
        rate[i] <= '0;
        cmd[i] <= '0;
      end
    end else begin
      cfg_event <= 1'b0;
      if (wr && paddr == OFF_CTRL) begin
        ctrl <= pwdata;
        cfg_event <= 1'b1;
      end
      if (wr && paddr == OFF_LEN) begin
        if (pwdata[7:0] == 8'h00 || pwdata[7:0] == cmd_words)
          fdbk_len <= pwdata[7:0];
        if ({1'b0, pwdata[15:8]} <= (ctrl[C_VAR8] ? DIAG_MAX_8 : {1'b0, DIAG_MAX_4}))
          diag_len <= {1'b0, pwdata[15:8]};
        if (pwdata[21:16] == 6'h00 || pwdata[21:16] == STAT_BITS)
          stat_len <= pwdata[21:16];
      end
      for (int i = 0; i < NCH; i++) begin
        if (wr && paddr[11:6] == OFF_CHCFG[11:6] && idx == 4'(i)) begin
          chcfg[i] <= pwdata;
          cfg_event <= 1'b1;
        end
        if (wr && paddr[11:6] == OFF_DFLT[11:6] && idx == 4'(i))
          dflt[i] <= pwdata;
        if (wr && paddr[11:6] == OFF_RATE[11:6] && idx == 4'(i))
          rate[i] <= pwdata;
        if (wr && paddr[11:6] == OFF_CMD[11:6] && idx == 4'(i) && 8'(2 * i) < cmd_words)
          cmd[i] <= pwdata;
      end
    end
  end

  // service-request module reset latches hold until next config store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      svc_hold <= 1'b0;
    else if (host_service_request && host_service_code == SVC_RESET_CODE)
      svc_hold <= 1'b1;
    else if (cfg_event)
      svc_hold <= 1'b0;
  end

  // a store is a one-cycle pulse; keep it until the tick so the reconfiguration is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_pend <= 1'b0;
    else if (cfg_event)
      cfg_pend <= 1'b1;
    else if (tick)
      cfg_pend <= 1'b0;
  end

  // marks the tick whose mode came from a store; the engine acts on it one tick later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_mode <= 1'b0;
    else if (tick)
      cfg_mode <= cfg_pend;
  end

  // first store after backplane power return steps without ramp unless analog power was kept
  // cleared only once the engine has used it, so the step really happens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      first_store <= 1'b1;
    else if (!s_bp[1])
      first_store <= 1'b1;
    else if (tick && cfg_mode)
      first_store <= 1'b0;
  end

  // mode selection
  logic defaulting;
  assign defaulting = !s_hen[1] || !s_bp[1] || !s_hc[1] || !s_io[1] || !s_fp[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode <= MD_HOLD;
    else if (tick) begin
      if (!s_fp[1])
        mode <= MD_ZERO;
      else if ((s_hr[1] && s_hen[1]) || svc_hold)
        mode <= MD_HOLD;
      else if (defaulting || cfg_pend)
        mode <= ctrl[C_HOLD] ? MD_HOLD : MD_DEFAULT;
      else
        mode <= MD_RUN;
    end
  end

  // per-channel output engine, reached once per tick
  logic step_now;
  // power-bad or first store skips ramp; kept analog power cancels only the first-store step, power-bad still steps
  assign step_now = !s_bp[1] || (first_store && !s_ap[1]);
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [31:0] tgt;
    logic        ramp;
    logic [31:0] diff;
    always_comb begin
      tgt = outv[g];
      ramp = 1'b0;
      case (mode)
        MD_RUN: begin
          tgt = cmd[g];
          ramp = ctrl[C_RAMPEN];
        end
        MD_DEFAULT: begin
          tgt = dflt[g];
          ramp = ctrl[C_DRAMP] && !step_now;
        end
        MD_HOLD: tgt = outv[g];
        MD_ZERO: tgt = ZERO_OUT;
        default: tgt = outv[g];
      endcase
      if (aod_rtype_t'(chcfg[g][1:0]) != RT_CURVOLT)
        tgt = ZERO_OUT;
      diff = (tgt > outv[g]) ? tgt - outv[g] : outv[g] - tgt;
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        outv[g] <= ZERO_OUT;
      else if (tick) begin
        if (!ramp || rate[g] == 32'h0000_0000 || diff <= rate[g])
          outv[g] <= tgt;
        else if (tgt > outv[g])
          outv[g] <= outv[g] + rate[g];
        else
          outv[g] <= outv[g] - rate[g];
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        analog_output_table[g*CW +: CW] <= '0;
        chan_fault[g] <= 1'b0;
      end else begin
        analog_output_table[g*CW +: CW] <= outv[g];
        chan_fault[g] <= s_cf[g] && (s_tb[1] || ctrl[C_FLTTB]);
      end
    end
  end

  // module fault and interrupt reporting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_report <= 1'b0;
      irq <= 1'b0;
    end else begin
      // terminal block loss is a module fault outside the master enable
      fault_report <= (ctrl[C_FLTEN] && ((ctrl[C_FPEN] && !s_fp[1])
                      || (ctrl[C_OTEN] && s_ot[1]))) || !s_tb[1];
      irq <= ctrl[C_IRQEN] && ((ctrl[C_IFPEN] && !s_fp[1])
             || (ctrl[C_IOTEN] && s_ot[1]));
    end
  end

  // apb read side; zero-wait, unmapped reads zero with pslverr
  logic [31:0] next_prdata;
  logic        next_err;
  always_comb begin
    next_prdata = '0;
    next_err = 1'b0;
    if (paddr == OFF_CTRL)
      next_prdata = ctrl;
    else if (paddr == OFF_STATUS)
      next_prdata = {26'h0, first_store, svc_hold, !s_tb[1], !s_fp[1],
                     !s_bp[1], s_ot[1]};
    else if (paddr == OFF_LEN)
      next_prdata = {10'h0, stat_len, diag_len[7:0], fdbk_len};
    else if (paddr[11:6] == OFF_CHCFG[11:6] && idx < 4'(NCH))
      next_prdata = chcfg[idx[2:0]];
    else if (paddr[11:6] == OFF_DFLT[11:6] && idx < 4'(NCH))
      next_prdata = dflt[idx[2:0]];
    else if (paddr[11:6] == OFF_RATE[11:6] && idx < 4'(NCH))
      next_prdata = rate[idx[2:0]];
    else if (paddr[11:6] == OFF_CMD[11:6] && idx < 4'(NCH))
      next_prdata = cmd[idx[2:0]];
    else if (paddr[11:6] == OFF_FDBK[11:6] && idx < 4'(NCH))
      next_prdata = (fdbk_len != 8'h00) ? cmd[idx[2:0]] : 32'h0000_0000;
    else if (paddr[11:6] == OFF_OUT[11:6] && idx < 4'(NCH))
      next_prdata = outv[idx[2:0]];
    else
      next_err = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  a_fp_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !s_fp[1]) |=> mode == MD_ZERO)
    else $error("field power loss not zeroing");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(ctrl[C_IRQEN]))
    else $error("irq without master enable");
  a_flt_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_report && $past(s_tb[1])) |-> $past(ctrl[C_FLTEN]))
    else $error("fault without enable");
  a_tb_fault: assert property (@(posedge pclk) disable iff (!presetn)
    !s_tb[1] |=> fault_report)
    else $error("terminal block loss not reported");
  a_svc_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (host_service_request && host_service_code == SVC_RESET_CODE) |=> svc_hold)
    else $error("service reset not latched");
  a_tb_supp: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_tb[1] && !ctrl[C_FLTTB]) |=> chan_fault == '0)
    else $error("channel fault without terminal block");
  a_hold_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_fp[1] && s_hr[1] && s_hen[1]) |=> mode == MD_HOLD)
    else $error("hot removal not holding");
  a_dis_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && chcfg[0][1:0] != 2'(RT_CURVOLT)) |=> outv[0] == ZERO_OUT)
    else $error("disabled channel not zero");
  a_ot_stat: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ot[1] && rd && paddr == OFF_STATUS) |-> next_prdata[0])
    else $error("over-temp bit missing");
  a_bp_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && mode == MD_DEFAULT && !s_bp[1] && chcfg[0][1:0] == 2'(RT_CURVOLT))
    |=> outv[0] == $past(dflt[0]))
    else $error("power bad default not immediate");
  a_first_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && mode == MD_DEFAULT && first_store && !s_ap[1] && s_bp[1]
     && chcfg[0][1:0] == 2'(RT_CURVOLT))
    |=> outv[0] == $past(dflt[0]))
    else $error("first store default not immediate");
  c_default: cover property (@(posedge pclk) mode == MD_DEFAULT);
  c_dramp: cover property (@(posedge pclk) mode == MD_DEFAULT && ctrl[C_DRAMP]);
  c_zero: cover property (@(posedge pclk) mode == MD_ZERO);
  c_run: cover property (@(posedge pclk) mode == MD_RUN && ctrl[C_RAMPEN]);
  c_irq: cover property (@(posedge pclk) irq);
endmodule

/* File: aod_ctrl_tb.sv */
module aod_ctrl_tb;
  import aod_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CMD  = 32'h4120_0000;
  localparam logic [31:0] CMD2 = 32'h40a0_0000;
  localparam logic [31:0] DFL  = 32'h3f80_0000;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               field_power_ok, over_temp, tb_present, hot_removal;
  logic               analog_power_kept, host_service_request, fault_report, irq;
  logic [3:0]         ok;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [7:0]         host_service_code;
  logic [NCH-1:0]     chan_fault_raw, chan_fault;
  logic [NCH*CW-1:0]  analog_output_table;
  int                 mismatches, check_count;
  aod_ctrl aod_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .host_out_en(ok[3]), .bp_power_ok(ok[2]),
    .host_comm_ok(ok[1]), .io_comm_ok(ok[0]), .field_power_ok, .over_temp, .tb_present,
    .hot_removal, .analog_power_kept, .chan_fault_raw, .host_service_request,
    .host_service_code, .analog_output_table, .chan_fault, .fault_report, .irq);
  aod_host aod_host_inst (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata, .host_service_request, .host_service_code);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    aod_host_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    aod_host_inst.xfer(1'b1, a, d, q, e);
  endtask
  // analog outputs move only on the update tick, plus sync delay; fault and irq outputs after sync delay alone
  task automatic settle;
    repeat (350) @(posedge pclk);
  endtask
  // waits for channel 0 to leave a value; bounded, a stuck output shows up in the next compare
  task automatic wait_out(input logic [31:0] old);
    int n;
    n = 0;
    while (analog_output_table[31:0] === old && n < 400) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic test_reset;
    logic [31:0] q;
    logic        e;
    rdchk(OFF_CTRL, CTRL_RST);
    rdchk(OFF_LEN, 32'h0000_0000);
    rdchk(OFF_CHCFG, CHCFG_RST);
    aod_host_inst.xfer(1'b0, 12'hffc, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(analog_output_table[31:0], ZERO_OUT);
  endtask
  task automatic test_echo;
    wr(OFF_LEN, 32'h0020_0008);
    wr(OFF_LEN, 32'h0010_0008);
    rdchk(OFF_LEN, 32'h0020_0008);
    wr(OFF_CHCFG, 32'h0000_0012);
    wr(OFF_CMD, CMD);
    wr(OFF_CMD + 12'h004, CMD);
    wr(OFF_CMD + 12'h010, CMD);
    rdchk(OFF_FDBK, CMD);
    rdchk(OFF_FDBK + 12'h010, ZERO_OUT);
    settle;
    chk(analog_output_table[31:0], CMD);
    chk(analog_output_table[63:32], ZERO_OUT);
  endtask
  task automatic test_causes;
    wr(OFF_DFLT, DFL);
    wr(OFF_CTRL, 32'h0000_0070);
    for (int i = 0; i < 4; i++) begin
      ok <= 4'hf ^ (4'h1 << i);
      settle;
      chk(analog_output_table[31:0], DFL);
      ok <= 4'hf;
      settle;
      chk(analog_output_table[31:0], CMD);
    end
    field_power_ok <= 1'b0;
    settle;
    chk(analog_output_table[31:0], ZERO_OUT);
    chk({31'h0, fault_report}, 32'h0000_0001);
    field_power_ok <= 1'b1;
  endtask
  task automatic test_status;
    logic [31:0] q;
    logic        e;
    over_temp <= 1'b1;
    settle;
    chk({31'h0, irq}, 32'h0000_0000);
    chk({31'h0, fault_report}, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0530);
    settle;
    chk({31'h0, irq}, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0020);
    settle;
    chk({31'h0, fault_report}, 32'h0000_0000);
    aod_host_inst.xfer(1'b0, OFF_STATUS, 32'h0000_0000, q, e);
    chk({31'h0, q[0]}, 32'h0000_0001);
    over_temp <= 1'b0;
  endtask
  task automatic test_hold;
    wr(OFF_CTRL, 32'h0000_0031);
    settle;
    ok <= 4'h7;
    settle;
    wr(OFF_CMD, CMD2);
    settle;
    chk(analog_output_table[31:0], CMD);
    ok <= 4'hf;
    settle;
    chk(analog_output_table[31:0], CMD2);
  endtask
  task automatic test_svc;
    wr(OFF_CTRL, 32'h0000_0030);
    settle;
    aod_host_inst.svc(SVC_RESET_CODE);
    ok <= 4'h7;
    settle;
    chk(analog_output_table[31:0], CMD2);
    ok <= 4'hf;
    wr(OFF_CTRL, 32'h0000_0030);
    settle;
    hot_removal <= 1'b1;
    ok <= 4'hd;
    settle;
    chk(analog_output_table[31:0], CMD2);
    hot_removal <= 1'b0;
    ok <= 4'hf;
  endtask
  task automatic test_chan;
    chan_fault_raw <= 8'h01;
    settle;
    chk({24'h0, chan_fault}, 32'h0000_0001);
    tb_present <= 1'b0;
    settle;
    chk({24'h0, chan_fault}, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0002);
    settle;
    chk({24'h0, chan_fault}, 32'h0000_0001);
    chk({31'h0, fault_report}, 32'h0000_0001);
    tb_present <= 1'b1;
    chan_fault_raw <= 8'h00;
  endtask
  task automatic test_ramp;
    wr(OFF_CMD, 32'h0000_0800);
    wr(OFF_RATE, 32'h0000_0100);
    wr(OFF_DFLT, 32'h0000_0000);
    settle;
    wr(OFF_CTRL, 32'h0000_6070);
    settle;
    chk(analog_output_table[31:0], 32'h0000_0800);
    wr(OFF_CMD, 32'h0000_0c00);
    wait_out(32'h0000_0800);
    chk(analog_output_table[31:0], 32'h0000_0900);
    settle;
    chk(analog_output_table[31:0], 32'h0000_0c00);
    ok <= 4'hd;
    wait_out(32'h0000_0c00);
    chk(analog_output_table[31:0], 32'h0000_0b00);
    ok <= 4'h9;
    wait_out(32'h0000_0b00);
    chk(analog_output_table[31:0], 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_4070);
    settle;
    ok <= 4'hf;
    settle;
    chk(analog_output_table[31:0], 32'h0000_0c00);
    wr(OFF_CTRL, 32'h0000_4070);
    wait_out(32'h0000_0c00);
    chk(analog_output_table[31:0], 32'h0000_0000);
    settle;
    wr(OFF_CTRL, 32'h0000_4070);
    wait_out(32'h0000_0c00);
    chk(analog_output_table[31:0], 32'h0000_0b00);
  endtask
  // run is about 11k cycles; the limit leaves wide margin
  initial begin
    #400_000;
    mismatches++;
    wrap_up;
  end
  initial begin
    mismatches = 0;
    check_count = 0;
    presetn = 1'b0;
    ok = 4'hf;
    field_power_ok = 1'b1;
    over_temp = 1'b0;
    tb_present = 1'b1;
    hot_removal = 1'b0;
    analog_power_kept = 1'b0;
    chan_fault_raw = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset;
    test_echo;
    test_causes;
    test_status;
    test_hold;
    test_svc;
    test_chan;
    test_ramp;
    wrap_up;
  end
endmodule

/* File: aod_host.sv */
module aod_host
  import aod_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic             host_service_request,
  output logic [7:0]       host_service_code
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    host_service_request = 1'b0;
    host_service_code = 8'h00;
  end
  // request stays put until pready is seen; one idle edge keeps back-to-back calls apart
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic svc(input logic [7:0] code);
    host_service_request <= 1'b1;
    host_service_code    <= code;
    @(posedge pclk);
    host_service_request <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

/* File: aod_pkg.sv */
package aod_pkg;
  localparam int NCH = 8;
  localparam int CW = 32;
  localparam logic [7:0] CMD_WORDS_4 = 8'h08;
  localparam logic [7:0] CMD_WORDS_8 = 8'h10;
  localparam logic [7:0] DIAG_MAX_4 = 8'h80;
  localparam logic [8:0] DIAG_MAX_8 = 9'h100;
  localparam logic [5:0] STAT_BITS = 6'h20;
  localparam logic [7:0] SVC_RESET_CODE = 8'h18;
  localparam logic [31:0] ZERO_OUT = 32'h0000_0000;
  localparam int UPD_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int UPD_CYC = UPD_NS / CLK_NS;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_LEN = 12'h008;
  localparam logic [11:0] OFF_CHCFG = 12'h040;
  localparam logic [11:0] OFF_DFLT = 12'h080;
  localparam logic [11:0] OFF_RATE = 12'h0c0;
  localparam logic [11:0] OFF_CMD = 12'h100;
  localparam logic [11:0] OFF_FDBK = 12'h140;
  localparam logic [11:0] OFF_OUT = 12'h180;
  localparam logic [31:0] CTRL_RST = 32'h0000_0070;
  // disabled current, plus/minus ten volts, float format (bit 8 low)
  localparam logic [31:0] CHCFG_RST = 32'h0000_0000;
  localparam int C_HOLD = 0;
  localparam int C_FLTTB = 1;
  localparam int C_FLTEN = 4;
  localparam int C_FPEN = 5;
  localparam int C_OTEN = 6;
  localparam int C_IRQEN = 8;
  localparam int C_IFPEN = 9;
  localparam int C_IOTEN = 10;
  localparam int C_OUTEN = 12;
  localparam int C_RAMPEN = 13;
  localparam int C_DRAMP = 14;
  localparam int C_VAR8 = 15;
  typedef enum logic [1:0] {RT_DIS_CUR, RT_DIS_VOLT, RT_CURVOLT} aod_rtype_t;
  typedef enum logic [1:0] {RG_PM10V, RG_0_10V, RG_4_20MA, RG_0_20MA} aod_range_t;
  typedef enum logic [1:0] {MD_RUN, MD_DEFAULT, MD_HOLD, MD_ZERO} aod_mode_t;
endpackage
